//--- hw/lcd_instruction_decoder.v
// Instruction interpreter of a character display controller
// Operation
// - Reset: tempco zero, voltages zero, multiplier four
// - Select bit picks instruction or data register
// - Link control byte: continuation, select, zeros
// - Link direction comes from address bit
// - Busy discards all but status read
// - Clear fills blanks, homes, forces increment
// - Clear busy 165 cycles, others three
// - Return home zeroes pointer, unshifts display
// - Entry mode steps pointer up or down
// - Shift enabled text writes shift display
// - Display control latches on, cursor, blink
// - Display off blanks panel, stops generator
// - Cursor: five dots on eighth line
// - Blink alternates pattern and all dots
// - Cursor or display shift, left/right
// - Pattern address loads low six bits
// - Data write/read at pointer; status read
// - Extended set latches screen, display, icon, tempco
// - Voltage code stores char or icon voltage
// - Mirroring bits order columns and rows
// - Status returns busy and pointer
// - Data write steps pointer; pattern keeps five bits
// - Link function set forces byte width
`timescale 1ns/1ps
`default_nettype none
`include "instr_consts.vh"
module lcd_instruction_decoder
(
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       xfer_valid,
	input  wire       reg_select,
	input  wire       read_not_write,
	input  wire       link_mode,
	input  wire [7:0] wr_byte,
	output reg  [7:0] rd_byte,
	output reg        rd_valid,
	output reg        busy_indicator,
	output reg  [6:0] ram_pointer,
	output reg        ptr_in_pattern,
	output reg        increment_dir,
	output reg        shift_enable,
	output reg        display_on,
	output reg        cursor_on,
	output reg        blink_on,
	output reg  [7:0] display_shift,
	output reg        bus_width_bit,
	output reg        two_line,
	output reg        reduced_mux_bit,
	output reg        extended_set,
	output reg        screen_mirror,
	output reg        column_mirror,
	output reg        row_mirror,
	output reg        icon_only,
	output reg        icon_flash,
	output reg        bypass_gen,
	output reg        tempco_hi,
	output reg        tempco_lo,
	output reg        stages_hi,
	output reg        stages_lo,
	output reg  [5:0] char_voltage_reg,
	output reg  [5:0] icon_voltage_reg,
	output reg        panel_enable,
	output reg        gen_enable,
	output reg        clock_stoppable,
	output reg        cursor_line_on,
	output reg        cursor_block_on
);
	// ************************************************************
	// Storage and holding registers
	// ************************************************************
	reg [7:0] text_ram [0:79];
	reg [4:0] pattern_ram [0:127];
	reg [7:0] instruction_holding_reg;
	reg [7:0] transfer_holding_reg;
	reg       clearing_reg;
	reg [6:0] clear_idx_reg;
	reg [1:0] off_cnt_reg;
	wire      busy_run;
	wire      blink_phase;
	reg       exec_load;
	reg [7:0] exec_count;

	step_counter exec_timer
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (exec_load),
		.count   (exec_count),
		.running (busy_run)
	);

	blink_timer blinker
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.phase   (blink_phase)
	);

	// ************************************************************
	// Acceptance and cycle count selection
	// ************************************************************
	wire status_rd = xfer_valid & ~reg_select & read_not_write;
	// Reserved extended code is refused outright and raises no busy
	wire is_rsvd   = ~reg_select & extended_set & (wr_byte == 8'h01) & ~read_not_write;
	wire accept    = xfer_valid & ~status_rd & ~busy_indicator & ~is_rsvd;
	wire is_clear  = ~reg_select & ~extended_set & (wr_byte == 8'h01) & ~read_not_write;
	always @*
	begin
		exec_load  = accept;
		// Busy flag is a register, so the counter is loaded one short
		exec_count = is_clear ? `CYC_CLEAR - 8'd1 : `CYC_NORMAL - 8'd1;
	end

	wire [6:0] step_ptr = increment_dir ? ram_pointer + 7'd1 : ram_pointer - 7'd1;

	// ************************************************************
	// Instruction execution
	// ************************************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ram_pointer      <= 7'h00;
			ptr_in_pattern   <= 1'b0;
			increment_dir    <= 1'b1;
			shift_enable     <= 1'b0;
			display_on       <= 1'b0;
			cursor_on        <= 1'b0;
			blink_on         <= 1'b0;
			display_shift    <= 8'h00;
			bus_width_bit    <= 1'b1;
			two_line         <= 1'b0;
			reduced_mux_bit  <= 1'b0;
			extended_set     <= 1'b0;
			screen_mirror    <= 1'b0;
			column_mirror    <= 1'b0;
			row_mirror       <= 1'b0;
			icon_only        <= 1'b0;
			icon_flash       <= 1'b0;
			bypass_gen       <= 1'b0;
			tempco_hi        <= 1'b0;
			tempco_lo        <= 1'b0;
			{stages_hi, stages_lo} <= `STAGES_RESET;
			char_voltage_reg <= 6'h00;
			icon_voltage_reg <= 6'h00;
			instruction_holding_reg <= 8'h00;
			transfer_holding_reg    <= 8'h00;
			rd_byte          <= 8'h00;
			rd_valid         <= 1'b0;
			busy_indicator   <= 1'b0;
			// Power-on sequence includes a clear
			clearing_reg     <= 1'b1;
			clear_idx_reg    <= 7'h00;
		end
		else
		begin
			rd_valid       <= 1'b0;
			busy_indicator <= busy_run | accept;
			if (clearing_reg)
			begin
				text_ram[clear_idx_reg] <= `BLANK_CHAR;
				if (clear_idx_reg == 7'd79)
					clearing_reg <= 1'b0;
				clear_idx_reg <= clear_idx_reg + 7'd1;
			end
			if (status_rd)
			begin
				rd_byte  <= {busy_indicator, ram_pointer};
				rd_valid <= 1'b1;
			end
			else if (accept && reg_select)
			begin
				if (read_not_write)
				begin
					rd_byte  <= transfer_holding_reg;
					rd_valid <= 1'b1;
					transfer_holding_reg <= ptr_in_pattern ?
						{3'b000, pattern_ram[step_ptr]} : text_ram[step_ptr % 7'd80];
					ram_pointer <= step_ptr;
				end
				else
				begin
					if (ptr_in_pattern)
						pattern_ram[ram_pointer] <= wr_byte[4:0];
					else
					begin
						text_ram[ram_pointer % 7'd80] <= wr_byte;
						if (shift_enable)
							display_shift <= increment_dir ? display_shift - 8'd1 : display_shift + 8'd1;
					end
					ram_pointer <= step_ptr;
				end
			end
			else if (accept)
			begin
				instruction_holding_reg <= wr_byte;
				if (wr_byte[7:5] == 3'b001)
				begin
					bus_width_bit   <= link_mode ? 1'b1 : wr_byte[4];
					two_line        <= wr_byte[2];
					reduced_mux_bit <= wr_byte[1];
					extended_set    <= wr_byte[0];
				end
				else if (!extended_set)
				begin
					if (wr_byte == 8'h01)
					begin
						clearing_reg  <= 1'b1;
						clear_idx_reg <= 7'h00;
						ram_pointer   <= 7'h00;
						ptr_in_pattern <= 1'b0;
						display_shift <= 8'h00;
						increment_dir <= 1'b1;
					end
					else if (wr_byte[7:1] == 7'b0000001)
					begin
						ram_pointer    <= 7'h00;
						ptr_in_pattern <= 1'b0;
						display_shift  <= 8'h00;
					end
					else if (wr_byte[7:2] == 6'b000001)
					begin
						increment_dir <= wr_byte[1];
						shift_enable  <= wr_byte[0];
					end
					else if (wr_byte[7:3] == 5'b00001)
					begin
						display_on <= wr_byte[2];
						cursor_on  <= wr_byte[1];
						blink_on   <= wr_byte[0];
					end
					else if (wr_byte[7:4] == 4'b0001)
					begin
						if (wr_byte[3])
							display_shift <= wr_byte[2] ? display_shift + 8'd1 : display_shift - 8'd1;
						else
							ram_pointer <= wr_byte[2] ? ram_pointer + 7'd1 : ram_pointer - 7'd1;
					end
					else if (wr_byte[7:6] == 2'b01)
					begin
						ram_pointer[5:0] <= wr_byte[5:0];
						ptr_in_pattern   <= 1'b1;
						transfer_holding_reg <= {3'b000, pattern_ram[{ram_pointer[6], wr_byte[5:0]}]};
					end
					else if (wr_byte[7])
					begin
						ram_pointer    <= wr_byte[6:0];
						ptr_in_pattern <= 1'b0;
						transfer_holding_reg <= text_ram[wr_byte[6:0] % 7'd80];
					end
				end
				else
				begin
					if (wr_byte[7])
					begin
						if (wr_byte[6])
							icon_voltage_reg <= wr_byte[5:0];
						else
							char_voltage_reg <= wr_byte[5:0];
					end
					else if (wr_byte[7:1] == 7'b0000001)
						screen_mirror <= wr_byte[0];
					else if (wr_byte[7:2] == 6'b000001)
					begin
						column_mirror <= wr_byte[1];
						row_mirror    <= wr_byte[0];
					end
					else if (wr_byte[7:3] == 5'b00001)
					begin
						icon_only  <= wr_byte[2];
						icon_flash <= wr_byte[1];
						bypass_gen <= wr_byte[0];
					end
					else if (wr_byte[7:2] == 6'b000100)
					begin
						tempco_hi <= wr_byte[1];
						tempco_lo <= wr_byte[0];
					end
					else if (wr_byte[7:2] == 6'b010000)
					begin
						stages_hi <= wr_byte[1];
						stages_lo <= wr_byte[0];
					end
				end
			end
		end
	end

	// ************************************************************
	// Panel power and cursor presentation
	// ************************************************************
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			panel_enable    <= 1'b0;
			gen_enable      <= 1'b0;
			clock_stoppable <= 1'b1;
			// Settled count at reset, matching the stoppable clock
			off_cnt_reg     <= 2'd3;
			cursor_line_on  <= 1'b0;
			cursor_block_on <= 1'b0;
		end
		else
		begin
			panel_enable <= display_on;
			gen_enable   <= display_on & ~bypass_gen &
				((icon_only ? icon_voltage_reg : char_voltage_reg) != 6'h00);
			// Three cycles after display off before the clock may stop
			if (display_on)
				off_cnt_reg <= 2'd0;
			else if (off_cnt_reg != 2'd3)
				off_cnt_reg <= off_cnt_reg + 2'd1;
			clock_stoppable <= ~display_on & ({6'h00, off_cnt_reg} >= `CYC_OFF_SETTLE - 8'd1);
			// Cursor suppressed while pointer sits in pattern memory
			cursor_line_on  <= display_on & cursor_on & ~ptr_in_pattern;
			cursor_block_on <= display_on & blink_on & ~ptr_in_pattern & blink_phase;
		end
	end
endmodule // lcd_instruction_decoder
`default_nettype wire

//--- hw/instr_consts.vh
// Constants for the display instruction interpreter
`ifndef INSTR_CONSTS_VH
`define INSTR_CONSTS_VH
// ************************************************************
// Execution times in oscillator cycles
// ************************************************************
`define CYC_CLEAR        8'd165
`define CYC_NORMAL       8'd3
`define CYC_OFF_SETTLE   8'd3
// ************************************************************
// Reset values and fixed codes
// ************************************************************
`define STAGES_RESET     2'b10
`define BLANK_CHAR       8'h20
`define BLINK_DIV        17'd104448
`define TEXT_RAM_DEPTH   8'd80
`define PAT_RAM_DEPTH    8'd128
`define PAT_DATA_MASK    8'h1F
`endif

//--- hw/step_counter.v
// Down counter that reports completion of a loaded cycle count
`timescale 1ns/1ps
`default_nettype none
module step_counter
(
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       load,
	input  wire [7:0] count,
	output wire       running
);
	reg [7:0] cnt_reg;
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= 8'h00;
		else if (load)
			cnt_reg <= count;
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	assign running = (cnt_reg != 8'h00);
endmodule // step_counter
`default_nettype wire

//--- hw/blink_timer.v
// Free running divider giving the cursor blink phase
`timescale 1ns/1ps
`default_nettype none
`include "instr_consts.vh"
module blink_timer
(
	input  wire sys_clk,
	input  wire rst,
	output reg  phase
);
	reg [16:0] div_reg;
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			div_reg <= 17'h00000;
			phase   <= 1'b0;
		end
		else if (div_reg == `BLINK_DIV / 17'd2 - 17'd1)
		begin
			// Half period per phase, full period is the divide figure
			div_reg <= 17'h00000;
			phase   <= ~phase;
		end
		else
			div_reg <= div_reg + 17'h00001;
	end
endmodule // blink_timer
`default_nettype wire

//--- verification/decoder_checker.sv
// Concurrent checks on the instruction interpreter ports
`timescale 1ns/1ps
`default_nettype none
module decoder_checker
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       xfer_valid,
	input wire logic       reg_select,
	input wire logic       read_not_write,
	input wire logic [7:0] wr_byte,
	input wire logic [7:0] rd_byte,
	input wire logic       rd_valid,
	input wire logic       busy_indicator,
	input wire logic [6:0] ram_pointer,
	input wire logic       increment_dir,
	input wire logic       display_on,
	input wire logic       cursor_on,
	input wire logic       blink_on,
	input wire logic [7:0] display_shift,
	input wire logic       extended_set,
	input wire logic [5:0] char_voltage_reg,
	input wire logic [5:0] icon_voltage_reg,
	input wire logic       panel_enable,
	input wire logic       gen_enable
);
// ********
// Properties
// ********
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
wire instr = xfer_valid && !reg_select && !read_not_write;
wire stat  = xfer_valid && !reg_select && read_not_write;
wire clr   = instr && !busy_indicator && !extended_set && wr_byte == 8'h01;
// Extended code 01 is refused, so it raises no busy
wire acc   = xfer_valid && !busy_indicator && !stat && !(instr && extended_set && wr_byte == 8'h01);
sequence s_hold3;
	busy_indicator [*3] ##1 !busy_indicator;
endsequence
sequence s_hold165;
	busy_indicator [*8] ##157 busy_indicator ##1 !busy_indicator;
endsequence
AST_BUSY_THREE: assert property (acc && !clr |=> s_hold3) else $error("busy not three cycles");
AST_BUSY_CLEAR: assert property (clr |=> s_hold165) else $error("clear busy not 165 cycles");
AST_CLEAR_HOME: assert property (clr |=> ram_pointer == 7'h00 && increment_dir && display_shift == 8'h00)
	else $error("clear did not home");
AST_DROP: assert property (xfer_valid && busy_indicator && !stat |=> $stable(display_on) && $stable(cursor_on)
	&& $stable(blink_on) && $stable(extended_set)) else $error("busy transfer executed");
AST_STATUS: assert property (stat |=> rd_valid && rd_byte == {$past(busy_indicator), $past(ram_pointer)})
	else $error("status read wrong");
AST_NO_READ: assert property (!(xfer_valid && read_not_write) |=> !rd_valid) else $error("stray read pulse");
AST_DCTRL: assert property (acc && instr && !extended_set && wr_byte[7:3] == 5'b00001
	|=> {display_on, cursor_on, blink_on} == $past(wr_byte[2:0])) else $error("display control");
AST_VOLT: assert property (acc && instr && extended_set && wr_byte[7] |=> ($past(wr_byte[6])
	? icon_voltage_reg : char_voltage_reg) == $past(wr_byte[5:0])) else $error("voltage store");
AST_PANEL_OFF: assert property ($fell(display_on) |-> ##[0:3] (!panel_enable && !gen_enable))
	else $error("panel not off");
endmodule // decoder_checker
bind lcd_instruction_decoder decoder_checker i_decoder_checker (.sys_clk, .rst, .xfer_valid, .reg_select,
	.read_not_write, .wr_byte, .rd_byte, .rd_valid, .busy_indicator, .ram_pointer, .increment_dir, .display_on,
	.cursor_on, .blink_on, .display_shift, .extended_set, .char_voltage_reg, .icon_voltage_reg, .panel_enable,
	.gen_enable);
`default_nettype wire

//--- verification/host_model.sv
// Host model driving transfers and polling busy
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic       sys_clk,
	input  wire logic       busy_indicator,
	input  wire logic       rd_valid,
	input  wire logic [7:0] rd_byte,
	output var  logic       xfer_valid,
	output var  logic       reg_select,
	output var  logic       read_not_write,
	output var  logic       link_mode,
	output var  logic [7:0] wr_byte,
	output var  logic [7:0] got,
	output var  logic       timed_out
);
// ********
// Transfers
// ********
initial
begin
	xfer_valid = 1'b0;
	reg_select = 1'b0;
	read_not_write = 1'b0;
	link_mode = 1'b0;
	wr_byte = 8'h00;
	got = 8'h00;
	timed_out = 1'b0;
end
task automatic xfer(input logic rs, input logic rnw, input logic lm, input logic [7:0] b, input logic poll);
	int n;
	begin
		@(negedge sys_clk);
		reg_select = rs;
		read_not_write = rnw;
		link_mode = lm;
		wr_byte = b;
		xfer_valid = 1'b1;
		@(negedge sys_clk);
		xfer_valid = 1'b0;
		// Released bus shows the inverse, never a stale copy
		wr_byte = ~b;
		if (rd_valid === 1'b1)
			got = rd_byte;
		n = 0;
		@(negedge sys_clk);
		while (poll && busy_indicator !== 1'b0 && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 400)
			timed_out = 1'b1;
	end
endtask
endmodule // host_model
`default_nettype wire

//--- verification/test_lcd_instruction_decoder.sv
// Self-checking bench for the instruction interpreter
`timescale 1ns/1ps
`default_nettype none
module test_lcd_instruction_decoder;
// ********
// Clock, reset, instances
// ********
logic sys_clk = 1'b0;
logic rst = 1'b1;
logic xfer_valid, reg_select, read_not_write, link_mode, timed_out;
logic [7:0] wr_byte, rd_byte, display_shift, got, v;
logic [6:0] ram_pointer;
logic [5:0] char_voltage_reg, icon_voltage_reg;
logic rd_valid, busy_indicator, ptr_in_pattern, increment_dir, shift_enable, display_on, cursor_on, blink_on;
logic bus_width_bit, two_line, reduced_mux_bit, extended_set, column_mirror, row_mirror;
logic tempco_hi, tempco_lo, stages_hi, stages_lo, panel_enable, gen_enable, clock_stoppable;
logic screen_mirror, icon_only, icon_flash, bypass_gen, cursor_line_on, cursor_block_on;
int err_total = 0;
int cmp_count = 0;
int seed = 32'h73f83937;
initial
	forever #4 sys_clk = ~sys_clk;
lcd_instruction_decoder i_lcd_instruction_decoder (.sys_clk, .rst, .xfer_valid, .reg_select, .read_not_write,
	.link_mode, .wr_byte, .rd_byte, .rd_valid, .busy_indicator, .ram_pointer, .ptr_in_pattern, .increment_dir,
	.shift_enable, .display_on, .cursor_on, .blink_on, .display_shift, .bus_width_bit, .two_line,
	.reduced_mux_bit, .extended_set, .screen_mirror, .column_mirror, .row_mirror, .icon_only, .icon_flash,
	.bypass_gen, .tempco_hi, .tempco_lo, .stages_hi, .stages_lo, .char_voltage_reg, .icon_voltage_reg,
	.panel_enable, .gen_enable, .clock_stoppable, .cursor_line_on, .cursor_block_on);
host_model i_host_model (.sys_clk, .busy_indicator, .rd_valid, .rd_byte, .xfer_valid, .reg_select,
	.read_not_write, .link_mode, .wr_byte, .got, .timed_out);
// ********
// Tasks
// ********
task automatic chk(input logic c);
	begin
		cmp_count++;
		if (c !== 1'b1)
		begin
			err_total++;
			$display("[ERR] %0t value mismatch", $time);
		end
	end
endtask
task automatic cmd(input logic [7:0] b);
	i_host_model.xfer(1'b0, 1'b0, 1'b0, b, 1'b1);
endtask
task automatic dat(input logic rnw, input logic [7:0] b);
	i_host_model.xfer(1'b1, rnw, 1'b0, b, 1'b1);
endtask
task print_verdict;
	begin
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
endtask
always @(posedge timed_out)
begin
	err_total++;
	print_verdict;
end
initial
begin
	repeat (50000) @(posedge sys_clk);
	err_total++;
	print_verdict;
end
// ********
// Scenarios
// ********
initial
begin
	repeat (6) @(posedge sys_clk);
	@(negedge sys_clk);
	rst = 1'b0;
	// Text RAM blank fill runs after reset
	repeat (100) @(negedge sys_clk);
	chk({tempco_hi, tempco_lo, stages_hi, stages_lo, char_voltage_reg, icon_voltage_reg} === 16'h2000);
	cmd(8'h26);
	chk({bus_width_bit, two_line, reduced_mux_bit} === 3'b011);
	// Width bit is low here, so the link function set must raise it
	i_host_model.xfer(1'b0, 1'b0, 1'b1, 8'h20, 1'b1);
	chk({bus_width_bit, two_line, reduced_mux_bit} === 3'b100);
	cmd(8'h30);
	for (int i = 0; i < 8; i++)
	begin
		cmd(8'h08 | i[7:0]);
		chk({display_on, cursor_on, blink_on} === i[2:0]);
	end
	cmd(8'h07);
	cmd(8'h90);
	v = $random(seed);
	dat(1'b0, v);
	chk(ram_pointer === 7'h11 && display_shift === 8'hFF);
	cmd(8'h05);
	dat(1'b0, ~v);
	chk(ram_pointer === 7'h10 && display_shift === 8'h00);
	cmd(8'h90);
	dat(1'b1, 8'h00);
	chk(got === v && ram_pointer === 7'h0F && display_shift === 8'h00);
	cmd(8'h1C);
	cmd(8'h10);
	chk(ram_pointer === 7'h0E && display_shift === 8'h01);
	cmd(8'h02);
	chk(ram_pointer === 7'h00 && display_shift === 8'h00 && {increment_dir, shift_enable} === 2'b01);
	cmd(8'hC5);
	cmd(8'h43);
	chk(ram_pointer === 7'h43 && ptr_in_pattern === 1'b1);
	dat(1'b0, 8'hFF);
	chk(ram_pointer === 7'h42 && display_shift === 8'h00);
	cmd(8'h43);
	dat(1'b1, 8'h00);
	chk(got === 8'h1F);
	cmd(8'h08);
	chk({panel_enable, gen_enable, clock_stoppable} === 3'b001);
	i_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h01, 1'b0);
	i_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h0C, 1'b0);
	i_host_model.xfer(1'b0, 1'b1, 1'b0, 8'h00, 1'b1);
	chk(got[7] === 1'b1 && got[6:0] === 7'h00 && display_on === 1'b0);
	chk(ram_pointer === 7'h00 && {increment_dir, shift_enable} === 2'b11);
	cmd(8'h90);
	dat(1'b1, 8'h00);
	chk(got === 8'h20);
	cmd(8'h0C);
	chk(panel_enable === 1'b1);
	cmd(8'h31);
	cmd(8'h03);
	cmd(8'h07);
	chk({screen_mirror, column_mirror, row_mirror, increment_dir, extended_set} === 5'h1F);
	cmd(8'h13);
	cmd(8'h41);
	chk({tempco_hi, tempco_lo, stages_hi, stages_lo} === 4'hD);
	v = $random(seed);
	cmd({2'b10, v[5:0]});
	cmd({2'b11, ~v[5:0]});
	chk(char_voltage_reg === v[5:0] && icon_voltage_reg === ~v[5:0]);
	// Icon mode runs the generator from the icon voltage
	cmd(8'h0E);
	chk({icon_only, icon_flash, bypass_gen} === 3'b110 && gen_enable === (v[5:0] != 6'h3F));
	cmd(8'h0F);
	chk(bypass_gen === 1'b1 && gen_enable === 1'b0);
	cmd(8'h30);
	cmd(8'h0E);
	chk(cursor_line_on === 1'b1 && cursor_block_on === 1'b0);
	cmd(8'h43);
	chk(cursor_line_on === 1'b0 && ptr_in_pattern === 1'b1);
	print_verdict;
end
endmodule // test_lcd_instruction_decoder
`default_nettype wire
